// ---- logic/bcs_pkg.sv ----
/*
 * Constants, state types and register map of the battery charge sequencer.
 * Assumes a 200 MHz pclk and that every analog decision arrives as a
 * comparator flag from outside the clock domain.
 */
package bcs_pkg;
    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_MHZ         = 200;
    localparam int BBM_DEAD_NS     = 10000;
    localparam int BBM_DEAD_CYC    = (BBM_DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int GATE_DT_NS      = 30;
    localparam int GATE_DT_CYC     = (GATE_DT_NS * CLK_MHZ + 999) / 1000;
    localparam int RFR_NS          = 80;
    localparam int RFR_CYC         = (RFR_NS * CLK_MHZ) / 1000;
    localparam int TICK_US         = 1000;
    localparam int TICK_CYC        = TICK_US * CLK_MHZ;
    localparam int SS_STEP_US      = 1600;
    localparam int SS_STEP_CYC     = SS_STEP_US * CLK_MHZ;
    localparam int SS_STEPS        = 8;
    localparam int PU_DLY_MS       = 30;
    localparam int SLP_EXIT_MS     = 30;
    localparam int PRE_TMO_MIN     = 30;
    localparam int PRE_TMO_MS      = PRE_TMO_MIN * 60000;
    localparam int KTTC_DMIN_PER_NF = 56;
    localparam int KTTC_MS_PER_NF  = KTTC_DMIN_PER_NF * 6000;
    localparam int BOOT_LOW_CYCLES = 3;
    localparam int PWM_PERIOD_CYC  = 333;
    // ********************************************************
    // Comparator flag positions
    // ********************************************************
    localparam int I_CE = 0, I_UVLO = 1, I_LOW = 2, I_ACIN = 3, I_W200 = 4, I_OVP = 5;
    localparam int I_REGOK = 6, I_REGOVL = 7, I_HOT = 8, I_TSF = 9, I_BLOWV = 10;
    localparam int I_BRECH = 11, I_FBRECH = 12, I_ITERM = 13, I_TTCLO = 14;
    localparam int I_TTCREF = 15, I_BOOTLO = 16, I_S5MV = 17, I_B2V = 18;
    localparam int I_AVGLO = 19, I_DPM = 20, I_PWM = 21, NIN = 22;
    // ********************************************************
    // Registers
    // ********************************************************
    localparam logic [7:0]  REG_TCAP  = 8'h00;
    localparam logic [7:0]  REG_ICHG  = 8'h04;
    localparam logic [7:0]  REG_STAT  = 8'h08;
    localparam logic [7:0]  REG_STMR  = 8'h0C;
    localparam logic [6:0]  TCAP_RST  = 7'h0A;
    localparam logic [15:0] ICHG_RST  = 16'h20FF;

    typedef enum logic [2:0] {C_IDLE = 3'b000, C_PRE = 3'b001, C_FAST = 3'b010,
                              C_DONE = 3'b011, C_FAULT = 3'b100} bcs_chg_t;
    typedef enum logic [2:0] {P_BAT = 3'b000, P_WAIT = 3'b001, P_BBA = 3'b010,
                              P_AC = 3'b011, P_DROP = 3'b100, P_BBB = 3'b101} bcs_pth_t;
    typedef enum logic [2:0] {G_OFF = 3'b000, G_DTH = 3'b001, G_HS = 3'b010,
                              G_DTL = 3'b011, G_LS = 3'b100, G_DTR = 3'b101,
                              G_RFR = 3'b110} bcs_gst_t;
endpackage

// ---- logic/bcs_top.sv ----
/*
 * Battery charge sequencer: charge state machine, safety timers,
 * power-path selector, soft-start reference and gate sequencing.
 * Assumes an APB master on pclk and asynchronous comparator flags.
 */
`timescale 1ns/100ps
`default_nettype none
module bcs_top #(
    parameter int TICK_CYCLES = bcs_pkg::TICK_CYC,
    parameter int SS_STEP_CYCLES = bcs_pkg::SS_STEP_CYC,
    parameter int PRE_TMO_TICKS = bcs_pkg::PRE_TMO_MS,
    parameter int PWM_PERIOD = bcs_pkg::PWM_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Comparator flags and enable pin
    input  wire logic [bcs_pkg::NIN-1:0]  cmp_flags,
    // Power path and converter
    output logic                          adapter_switch_drive,
    output logic                          battery_switch_drive,
    output logic                          hs_gate,
    output logic                          ls_gate,
    output logic      [7:0]               charge_ref,
    output logic                          charge_active,
    output logic                          charge_fault
);
    import bcs_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [NIN-1:0] s1;
        logic [NIN-1:0] s2;
        logic           ce_q;
        logic           rcv_q;
        bcs_chg_t       chg;
        bcs_pth_t       pth;
        bcs_gst_t       gst;
        logic [31:0]    tick_cnt;
        logic [31:0]    pu_ms;
        logic [31:0]    pre_ms;
        logic [31:0]    saf_ms;
        logic [31:0]    path_cnt;
        logic [31:0]    ss_cnt;
        logic [3:0]     ss_step;
        logic [7:0]     dpm_trim;
        logic [15:0]    per_cnt;
        logic [7:0]     dt_cnt;
        logic [2:0]     boot_cnt;
        logic           dcm_done;
        logic [6:0]     tcap;
        logic [15:0]    ichg;
        logic [31:0]    rdata;
        logic           rerr;
        logic [7:0]     ref_r;
    } bcs_st_t;

    bcs_st_t r, nxt;
    logic [NIN-1:0] f;
    logic tick, en, run, sync_md, cyc0, adp, tmr_en, term;
    logic [31:0] saf_lim;
    logic [15:0] ss_ref;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == REG_TCAP) || (a == REG_ICHG) || (a == REG_STAT) || (a == REG_STMR);
    endfunction

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        nxt = r;
        // Flags pass two flops; only s2 is read by logic
        nxt.s1 = cmp_flags;
        nxt.s2 = r.s1;
        f = r.s2;
        tick = (r.tick_cnt == 32'(TICK_CYCLES - 1));
        nxt.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;
        if (tick && r.pu_ms < 32'(PU_DLY_MS)) begin
            nxt.pu_ms = r.pu_ms + 32'h1;
        end
        // Every enable condition, stop conditions included
        en = f[I_CE] && !f[I_UVLO] && !f[I_LOW] && f[I_ACIN] && !f[I_OVP]
             && (r.pu_ms >= 32'(PU_DLY_MS)) && f[I_REGOK] && !f[I_REGOVL]
             && !f[I_HOT] && !f[I_TSF];
        tmr_en = !f[I_TTCLO] && !f[I_TTCREF];
        saf_lim = 32'(r.tcap) * 32'(KTTC_MS_PER_NF);
        term = !f[I_TTCLO] && f[I_FBRECH] && f[I_ITERM] && (r.ss_step == 4'(SS_STEPS));
        nxt.ce_q = f[I_CE];
        nxt.rcv_q = f[I_OVP] || f[I_LOW] || !f[I_ACIN];

        // Charge sequence
        case (r.chg)
            C_IDLE: begin
                if (en) begin
                    nxt.chg = f[I_BLOWV] ? C_PRE : C_FAST;
                    nxt.pre_ms = 32'h0;
                    nxt.ss_step = 4'h1;
                    nxt.ss_cnt = 32'h0;
                end
            end
            C_PRE: begin
                if (tick) begin
                    nxt.pre_ms = r.pre_ms + 32'h1;
                end
                if (r.pre_ms >= 32'(PRE_TMO_TICKS)) begin
                    nxt.chg = C_FAULT;
                end else if (!f[I_BLOWV]) begin
                    nxt.chg = C_FAST;
                    nxt.ss_step = 4'h1;
                    nxt.ss_cnt = 32'h0;
                end
            end
            C_FAST: begin
                if (r.ss_step != 4'(SS_STEPS)) begin
                    if (r.ss_cnt == 32'(SS_STEP_CYCLES - 1)) begin
                        nxt.ss_cnt = 32'h0;
                        nxt.ss_step = r.ss_step + 4'h1;
                    end else begin
                        nxt.ss_cnt = r.ss_cnt + 32'h1;
                    end
                end
                if (tmr_en && tick) begin
                    nxt.saf_ms = r.saf_ms + 32'h1;
                end
                if (tmr_en && r.saf_ms >= saf_lim) begin
                    nxt.chg = C_FAULT;
                end else if (term) begin
                    nxt.chg = C_DONE;
                end
            end
            C_DONE: begin
                if (f[I_BRECH]) begin
                    nxt.chg = C_IDLE;
                    nxt.saf_ms = 32'h0;
                end
            end
            C_FAULT: begin
                // Only a timer or precharge fault lands here
                if (f[I_BRECH] || !f[I_CE]) begin
                    nxt.chg = C_IDLE;
                    nxt.saf_ms = 32'h0;
                end
            end
            default: nxt.chg = C_IDLE;
        endcase
        if (!en && r.chg != C_FAULT) begin
            nxt.chg = C_IDLE;
        end
        if (f[I_CE] != r.ce_q) begin
            nxt.chg = C_IDLE;
            nxt.saf_ms = 32'h0;
        end
        if (f[I_TTCLO] || (r.rcv_q && !nxt.rcv_q)) begin
            nxt.saf_ms = 32'h0;
        end

        // Input limit trims current one step per tick
        if (tick) begin
            if (f[I_DPM] && r.dpm_trim != 8'hFF) begin
                nxt.dpm_trim = r.dpm_trim + 8'h1;
            end else if (!f[I_DPM] && r.dpm_trim != 8'h00) begin
                nxt.dpm_trim = r.dpm_trim - 8'h1;
            end
        end
        ss_ref = (16'(r.ichg[7:0]) * 16'(r.ss_step)) >> 3;
        if (r.chg == C_PRE) begin
            nxt.ref_r = r.ichg[15:8];
        end else if (r.chg == C_FAST) begin
            nxt.ref_r = (ss_ref[7:0] > r.dpm_trim) ? ss_ref[7:0] - r.dpm_trim : 8'h00;
        end else begin
            nxt.ref_r = 8'h00;
        end

        // Power path; lockout goes straight to battery, a lost adapter from P_AC only through P_DROP and P_BBB
        adp = f[I_ACIN] && !f[I_OVP];
        nxt.path_cnt = r.path_cnt + 32'h1;
        case (r.pth)
            P_BAT: begin
                nxt.path_cnt = 32'h0;
                if (adp) begin
                    nxt.pth = P_WAIT;
                end
            end
            P_WAIT: begin
                nxt.path_cnt = tick ? r.path_cnt + 32'h1 : r.path_cnt;
                if (!adp) begin
                    nxt.pth = P_BAT;
                end else if (r.path_cnt >= 32'(SLP_EXIT_MS)) begin
                    nxt.pth = P_BBA;
                    nxt.path_cnt = 32'h0;
                end
            end
            P_BBA: begin
                if (r.path_cnt == 32'(BBM_DEAD_CYC - 1)) begin
                    nxt.pth = P_AC;
                end
            end
            P_AC: begin
                if (!adp) begin
                    nxt.pth = P_DROP;
                end
            end
            P_DROP: begin
                nxt.path_cnt = 32'h0;
                if (f[I_W200] || f[I_OVP]) begin
                    nxt.pth = P_BBB;
                end else if (adp) begin
                    nxt.pth = P_AC;
                end
            end
            P_BBB: begin
                if (r.path_cnt == 32'(BBM_DEAD_CYC - 1)) begin
                    nxt.pth = P_BAT;
                end
            end
            default: nxt.pth = P_BAT;
        endcase
        if (f[I_UVLO]) begin
            nxt.pth = P_BAT;
        end

        // Gate sequencing
        run = (r.chg == C_PRE || r.chg == C_FAST) && en;
        sync_md = f[I_S5MV] && !f[I_B2V] && !f[I_AVGLO];
        cyc0 = (r.per_cnt == 16'h0);
        nxt.per_cnt = (r.per_cnt == 16'(PWM_PERIOD - 1)) ? 16'h0 : r.per_cnt + 16'h1;
        if (cyc0) begin
            nxt.dcm_done = 1'b0;
            nxt.boot_cnt = f[I_BOOTLO] ? ((r.boot_cnt == 3'h7) ? 3'h7 : r.boot_cnt + 3'h1)
                                       : 3'h0;
        end
        nxt.dt_cnt = r.dt_cnt + 8'h1;
        case (r.gst)
            G_OFF: begin
                nxt.dt_cnt = 8'h0;
                if (run && f[I_PWM]) begin
                    nxt.gst = G_DTH;
                end else if (run && !sync_md && f[I_BOOTLO] && !r.dcm_done) begin
                    // Dead time first, high side may have just turned off
                    nxt.gst = G_DTR;
                end else if (run && sync_md) begin
                    nxt.gst = G_DTL;
                end
            end
            G_DTH: begin
                if (r.dt_cnt == 8'(GATE_DT_CYC - 1)) begin
                    nxt.gst = G_HS;
                end
            end
            G_HS: begin
                nxt.dt_cnt = 8'h0;
                if (!run) begin
                    nxt.gst = G_OFF;
                end else if (r.boot_cnt > 3'(BOOT_LOW_CYCLES)) begin
                    nxt.gst = G_DTR;
                end else if (!f[I_PWM]) begin
                    nxt.gst = sync_md ? G_DTL : G_OFF;
                end
            end
            G_DTL, G_DTR: begin
                if (r.dt_cnt == 8'(GATE_DT_CYC - 1)) begin
                    nxt.gst = (r.gst == G_DTR) ? G_RFR : G_LS;
                    nxt.dt_cnt = 8'h0;
                end
            end
            G_LS: begin
                nxt.dt_cnt = 8'h0;
                if (!run || !sync_md) begin
                    nxt.gst = G_OFF;
                end else if (f[I_PWM]) begin
                    nxt.gst = G_DTH;
                end
            end
            G_RFR: begin
                if (r.dt_cnt == 8'(RFR_CYC - 1)) begin
                    nxt.gst = G_OFF;
                    nxt.dcm_done = 1'b1;
                    nxt.boot_cnt = 3'h0;
                end
            end
            default: nxt.gst = G_OFF;
        endcase

        // APB: data captured in setup, write on access
        if (psel && !penable) begin
            nxt.rerr = !addr_ok(paddr);
            case (paddr)
                REG_TCAP: nxt.rdata = {25'h0, r.tcap};
                REG_ICHG: nxt.rdata = {16'h0, r.ichg};
                REG_STAT: nxt.rdata = {16'h0, r.ref_r, 1'b0, r.pth, 1'b0, r.chg};
                REG_STMR: nxt.rdata = r.saf_ms;
                default:  nxt.rdata = 32'h0;
            endcase
        end
        if (psel && penable && pwrite) begin
            if (paddr == REG_TCAP) begin
                nxt.tcap = pwdata[6:0];
            end
            if (paddr == REG_ICHG) begin
                nxt.ichg = pwdata[15:0];
            end
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{s1: '0, s2: '0, ce_q: 1'b0, rcv_q: 1'b0, chg: C_IDLE, pth: P_BAT,
                   gst: G_OFF, tick_cnt: 32'h0, pu_ms: 32'h0, pre_ms: 32'h0,
                   saf_ms: 32'h0, path_cnt: 32'h0, ss_cnt: 32'h0, ss_step: 4'h0,
                   dpm_trim: 8'h00, per_cnt: 16'h0, dt_cnt: 8'h0, boot_cnt: 3'h0,
                   dcm_done: 1'b0, tcap: TCAP_RST, ichg: ICHG_RST, rdata: 32'h0,
                   rerr: 1'b0, ref_r: 8'h00};
        end else begin
            r <= nxt;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign adapter_switch_drive = (r.pth == P_AC) || (r.pth == P_DROP);
    assign battery_switch_drive = (r.pth == P_BAT) || (r.pth == P_WAIT);
    assign hs_gate = (r.gst == G_HS);
    assign ls_gate = (r.gst == G_LS) || (r.gst == G_RFR);
    assign charge_ref = r.ref_r;
    assign charge_active = (r.chg == C_PRE) || (r.chg == C_FAST);
    assign charge_fault = (r.chg == C_FAULT);
    assign prdata = r.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && r.rerr;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_UVLO_PATH: assert property (r.s2[I_UVLO] |=> battery_switch_drive && !adapter_switch_drive)
        else $error("lockout did not select battery");
    AST_BBM_AC: assert property ($rose(adapter_switch_drive) |-> $past(r.pth) == P_BBA
        && $past(r.path_cnt) == 32'(BBM_DEAD_CYC - 1))
        else $error("adapter switch on without full dead time");
    AST_NO_BOTH: assert property (!(adapter_switch_drive && battery_switch_drive))
        else $error("both path switches on");
    AST_GATE_DT: assert property ($fell(hs_gate) |-> !ls_gate [*6])
        else $error("low side on inside dead time");
    AST_RFR_LEN: assert property ($rose(r.gst == G_RFR) |-> ls_gate [*8])
        else $error("refresh pulse too short");
    AST_STOP: assert property (charge_active && !r.s2[I_CE] |=> !charge_active)
        else $error("charge not stopped");
    AST_PRE_REF: assert property (r.chg == C_PRE |=> charge_ref == $past(r.ichg[15:8]))
        else $error("precharge reference wrong");
    AST_TTC_LOW: assert property (r.s2[I_TTCLO] |=> r.saf_ms == 32'h0)
        else $error("safety timer not held");
    AST_CE_TOG: assert property (r.s2[I_CE] != r.ce_q |=> r.saf_ms == 32'h0 && !charge_active)
        else $error("charge-allow toggle did not restart");
    AST_SS: assert property ($rose(r.chg == C_FAST) |-> r.ss_step == 4'h1)
        else $error("soft start not from first step");

    COV_AC: cover property ($rose(adapter_switch_drive));
    COV_DONE: cover property ($rose(r.chg == C_DONE));
    COV_RFR: cover property ($rose(r.gst == G_RFR));
    COV_FAULT: cover property ($rose(charge_fault));
endmodule // bcs_top
`default_nettype wire

// ---- verification/bcs_far_side.sv ----
/*
 * Far-side model: comparator flags, enable pin and PWM request.
 * Assumes the bench changes conditions just after rising pclk edges.
 */
`timescale 1ns/100ps
`default_nettype none
module bcs_far_side #(
    parameter int PERIOD = 40
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Conditions commanded by the bench
    input  wire logic [20:0] cond,
    // Flags into the block
    output logic      [21:0] cmp_flags
);
    // ********************************************************
    // PWM request, high for the first half of each period
    // ********************************************************
    int cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt <= 0;
        else
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
    // Host enable and comparators follow the commanded levels
    assign cmp_flags = {logic'(cnt < PERIOD / 2), cond};
endmodule // bcs_far_side
`default_nettype wire

// ---- verification/test_battery_charge_sequencer.sv ----
/*
 * Testbench of the charge sequencer: power path, charge cycle, stops, APB.
 * Assumes short sim parameters: tick 10, soft-start step 20, precharge 50 ticks.
 */
`timescale 1ns/100ps
`default_nettype none
module test_battery_charge_sequencer;
    import bcs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, charge_ref, prev;
    logic [31:0] pwdata, prdata, rd;
    logic [20:0] cond;
    logic [21:0] cmp_flags;
    logic        adapter_switch_drive, battery_switch_drive, hs_gate, ls_gate;
    logic        charge_active, charge_fault;
    int          mismatches, total_checks, overlap, n, steps;
    int          stops[4] = '{I_OVP, I_REGOVL, I_HOT, I_TSF};

    bcs_top #(.TICK_CYCLES(10), .SS_STEP_CYCLES(20), .PRE_TMO_TICKS(50), .PWM_PERIOD(40)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_flags(cmp_flags), .adapter_switch_drive(adapter_switch_drive),
        .battery_switch_drive(battery_switch_drive), .hs_gate(hs_gate), .ls_gate(ls_gate),
        .charge_ref(charge_ref), .charge_active(charge_active), .charge_fault(charge_fault));
    bcs_far_side #(.PERIOD(40)) i_far (.pclk(pclk), .presetn(presetn), .cond(cond),
        .cmp_flags(cmp_flags));

    // ********************************************************
    // Shared tasks
    // ********************************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (hs_gate === 1'b1 && ls_gate === 1'b1) overlap++;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: pick = battery_switch_drive;
            1: pick = adapter_switch_drive;
            2: pick = charge_active;
            default: pick = charge_fault;
        endcase
    endfunction
    // Bounded wait; a run-out counts as a mismatch and ends the run
    task automatic wait_on(input int s, input logic v, input int lim);
        n = 0;
        while (pick(s) !== v) begin
            if (n >= lim) begin
                mismatches++;
                stop_test();
            end
            // Sample away from the launching edge
            @(negedge pclk);
            n++;
        end
    endtask
    task automatic setc(input int b, input logic v);
        @(posedge pclk);
        cond[b] <= v;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            mismatches++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic s_regs;
        apb(1'b0, REG_TCAP, 32'h0);
        chk(rd, 32'h0000000A);
        apb(1'b0, REG_ICHG, 32'h0);
        chk(rd, 32'h000020FF);
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, REG_TCAP, 32'h00000003);
        apb(1'b0, REG_TCAP, 32'h0);
        chk(rd, 32'h00000003);
    endtask
    task automatic s_path;
        chk(32'({battery_switch_drive, adapter_switch_drive}), 32'h2);
        setc(I_REGOK, 1'b1);
        setc(I_ACIN, 1'b1);
        wait_on(0, 1'b0, 1000);
        chk(32'(n >= 290), 32'h1);
        wait_on(1, 1'b1, 3000);
        chk(32'(n >= BBM_DEAD_CYC && n <= BBM_DEAD_CYC + 3), 32'h1);
        chk(32'(battery_switch_drive), 32'h0);
    endtask
    task automatic s_fast;
        setc(I_CE, 1'b1);
        wait_on(2, 1'b1, 100);
        steps = 0;
        prev = charge_ref;
        for (int i = 0; i < 400 && charge_ref !== 8'hFF; i++) begin
            @(posedge pclk);
            if (charge_ref > prev)
                steps++;
            prev = charge_ref;
        end
        chk(32'(steps), 32'(SS_STEPS));
        setc(I_DPM, 1'b1);
        repeat (50) @(posedge pclk);
        chk(32'(charge_ref < 8'hFF), 32'h1);
        setc(I_DPM, 1'b0);
        setc(I_FBRECH, 1'b1);
        repeat (10) @(posedge pclk);
        chk(32'(charge_active), 32'h1);
        setc(I_ITERM, 1'b1);
        wait_on(2, 1'b0, 10);
        setc(I_FBRECH, 1'b0);
        setc(I_ITERM, 1'b0);
        setc(I_BRECH, 1'b1);
        wait_on(2, 1'b1, 10);
        setc(I_BRECH, 1'b0);
    endtask
    task automatic s_stop;
        foreach (stops[i]) begin
            setc(stops[i], 1'b1);
            wait_on(2, 1'b0, 10);
            setc(stops[i], 1'b0);
            wait_on(2, 1'b1, 3000);
        end
        setc(I_CE, 1'b0);
        wait_on(2, 1'b0, 10);
    endtask
    task automatic s_pre_timer;
        setc(I_BLOWV, 1'b1);
        setc(I_CE, 1'b1);
        wait_on(2, 1'b1, 20);
        repeat (4) @(posedge pclk);
        chk(32'(charge_ref), 32'h20);
        wait_on(3, 1'b1, 700);
        chk(32'(n >= 450), 32'h1);
        chk(32'(charge_active), 32'h0);
        setc(I_CE, 1'b0);
        wait_on(3, 1'b0, 10);
        setc(I_BLOWV, 1'b0);
        apb(1'b1, REG_TCAP, 32'h0);
        setc(I_CE, 1'b1);
        wait_on(3, 1'b1, 200);
        setc(I_TTCLO, 1'b1);
        setc(I_BRECH, 1'b1);
        wait_on(3, 1'b0, 10);
        setc(I_BRECH, 1'b0);
        wait_on(2, 1'b1, 20);
        repeat (100) @(posedge pclk);
        chk(32'(charge_fault), 32'h0);
    endtask
    task automatic s_uvlo;
        setc(I_UVLO, 1'b1);
        wait_on(0, 1'b1, 10);
        chk(32'({adapter_switch_drive, charge_active}), 32'h0);
        chk(32'(overlap), 32'h0);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cond = '0;
        cond[I_S5MV] = 1'b1;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_path();
        s_fast();
        s_stop();
        s_pre_timer();
        s_uvlo();
        stop_test();
    end
endmodule // test_battery_charge_sequencer
`default_nettype wire
